// ### spl_host_model.sv
// Purpose: host controller model issuing object dictionary reads and writes
// Assumes: one request per access, answer registered at the taking edge
// Notes: drives at the falling edge and samples the answer at the next falling edge
module spl_host_model (
  // clock
  input wire logic clk_in,
  // requests
  output logic [15:0] od_index_out,
  output logic [7:0] od_subindex_out,
  output logic od_wr_out,
  output logic od_rd_out,
  output logic [31:0] od_wdata_out,
  // answers
  input wire logic [31:0] od_rdata_in,
  input wire logic od_ack_in,
  input wire logic od_err_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    od_index_out = 16'h0000;
    od_subindex_out = 8'h00;
    od_wr_out = 1'b0;
    od_rd_out = 1'b0;
    od_wdata_out = 32'h0000_0000;
  end

  // one access; st returns {ack, err} as seen in the answer cycle
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] st);
    @(negedge clk_in);
    od_index_out = idx;
    od_subindex_out = sub;
    od_wr_out = wr;
    od_rd_out = !wr;
    od_wdata_out = wd;
    @(negedge clk_in);
    rd = od_rdata_in;
    st = {od_ack_in, od_err_in};
    od_wr_out = 1'b0;
    od_rd_out = 1'b0;
    // released data no longer shows the last word
    od_wdata_out = ~wd;
  endtask
endmodule

// ### spl_limit_cmp.sv
// Purpose: signed compare of one position against the minimum and maximum limits
// Assumes: limits are 32-bit signed, the sentinel word disables that side
// Notes: purely combinational; the top registers all results
module spl_limit_cmp #(
  parameter int W = 32
) (
  // value under test
  input wire logic signed [W-1:0] value_in,
  // limits
  input wire logic [31:0] min_in,
  input wire logic [31:0] max_in,
  // results
  output logic over_max_out,
  output logic under_min_out
);
  logic signed [W-1:0] min_ext;
  logic signed [W-1:0] max_ext;

  assign min_ext = W'(signed'(min_in));
  assign max_ext = W'(signed'(max_in));
  // sentinel turns off the negative side [RQ2]
  assign under_min_out = (min_in != spl_pkg::NO_LIMIT) && (value_in < min_ext);
  // sentinel turns off the positive side [RQ3]
  assign over_max_out = (max_in != spl_pkg::NO_LIMIT) && (value_in > max_ext);
endmodule

// ### spl_pkg.sv
// Purpose: shared constants for the soft position limit and modulus block
// Assumes: object dictionary access by index and subindex, 32-bit data
// Notes: limit word 0x8000_0000 is the "no limit" sentinel in either direction
package spl_pkg;
  // ****************************************************************
  // object dictionary addresses
  // ****************************************************************
  localparam logic [15:0] IDX_SWITCH = 16'h2781;
  localparam logic [15:0] IDX_MODMAX = 16'h278A;
  localparam logic [15:0] IDX_LIMIT = 16'h607D;
  localparam logic [15:0] IDX_HOME = 16'h607C;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_MIN = 8'h01;
  localparam logic [7:0] SUB_MAX = 8'h02;
  // ****************************************************************
  // reset values and field layout
  // ****************************************************************
  localparam logic [15:0] SWITCH_RST = 16'h0000;
  localparam logic [7:0] LIMIT_COUNT = 8'h02;
  localparam logic [31:0] LIMIT_RST = 32'h8000_0000;
  localparam logic [31:0] NO_LIMIT = 32'h8000_0000;
  localparam logic [32:0] MODMAX_RST = 33'h0_0000_0000;
  localparam logic [31:0] HOME_RST = 32'h0000_0000;
  localparam int SW_LIMIT_EN_BIT = 0;
  localparam int SW_MODULUS_BIT = 1;
  // ****************************************************************
  // operating mode codes
  // ****************************************************************
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_CYCLIC_POS = 8'h08;
endpackage

// ### spl_soft_limit.sv
// Purpose: soft position limit, overtravel warnings, target clamp and modulus count
// Assumes: position inputs synchronous to clk_in; restart_in pulses on drive restart
// Notes: switch and modulus settings act only from restart_in or reset
// Functional notes
// (RQ1) Switch bit 0 enables the soft limit, applied only at restart.
// (RQ2) A minimum of -2147483648 means no negative limit.
// (RQ3) A maximum word of 2147483648 (0x8000_0000) means no positive limit.
// (RQ4) The limit object reports two entries; min and max are signed 32-bit read-write.
// (RQ5) Feedback is compared with the limits in absolute and incremental systems alike.
// (RQ6) In profile or cyclic position mode a target outside the limits sets status bit 11 and a warning.
// (RQ7) In those modes the violated limit becomes the target and a stop is requested.
// (RQ8) In other modes feedback past a limit raises that direction's warning and a stop.
// (RQ9) Minimum above maximum raises the limit order error.
// (RQ10) Home offset outside the limits raises the home offset range error.
// (RQ11) In an absolute system switch bit 1 enables modulus mode, applied at restart.
// (RQ12) In modulus mode the feedback count stays within zero and the modulus maximum.
// (RQ13) The modulus count wraps max to zero going positive and zero to max going negative.
module spl_soft_limit #(
  parameter int POS_W = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic restart_in,
  // object dictionary access
  input wire logic [15:0] od_index_in,
  input wire logic [7:0] od_subindex_in,
  input wire logic od_wr_in,
  input wire logic od_rd_in,
  input wire logic [31:0] od_wdata_in,
  output logic [31:0] od_rdata_out,
  output logic od_ack_out,
  output logic od_err_out,
  // motion inputs
  input wire logic abs_system_in,
  input wire logic [7:0] op_mode_in,
  input wire logic signed [POS_W-1:0] target_pos_in,
  input wire logic pos_step_in,
  input wire logic signed [POS_W-1:0] pos_delta_in,
  // results
  output logic signed [POS_W:0] pos_feedback_out,
  output logic signed [POS_W-1:0] target_eff_out,
  output logic status_limit_out,
  output logic positive_overtravel_warning_out,
  output logic negative_overtravel_warning_out,
  output logic stop_req_out,
  output logic limit_order_error_out,
  output logic home_offset_range_error_out
);
  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] want_idx, input logic [7:0] want_sub);
    hit = (idx == want_idx) && (sub == want_sub);
  endfunction

  function automatic logic signed [POS_W:0] wrap_pos(input logic signed [POS_W:0] pos,
                                                     input logic signed [POS_W-1:0] delta,
                                                     input logic [32:0] mmax);
    logic signed [POS_W+2:0] sum;
    logic signed [POS_W+2:0] span;
    sum = (POS_W+3)'(pos) + (POS_W+3)'(delta);
    span = (POS_W+3)'($signed({1'b0, mmax})) + (POS_W+3)'(1);
    if (sum > span - (POS_W+3)'(1)) begin
      sum = sum - span;
    end else if (sum < (POS_W+3)'(0)) begin
      sum = sum + span;
    end
    wrap_pos = sum[POS_W:0];
  endfunction

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [15:0] switch_ff, nxt_switch;
  logic [31:0] min_ff, nxt_min;
  logic [31:0] max_ff, nxt_max;
  logic [32:0] modmax_ff, nxt_modmax;
  logic [31:0] home_ff, nxt_home;
  logic limit_en_ff, nxt_limit_en;
  logic modulus_en_ff, nxt_modulus_en;
  logic [32:0] modmax_act_ff, nxt_modmax_act;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic mapped;
  logic [31:0] rd_word;

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_SWITCH, spl_pkg::SUB_COUNT)) begin
      rd_word = {16'h0000, switch_ff};
    end else if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_MODMAX, spl_pkg::SUB_COUNT)) begin
      rd_word = modmax_ff[31:0];
    end else if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_LIMIT, spl_pkg::SUB_COUNT)) begin
      rd_word = {24'h00_0000, spl_pkg::LIMIT_COUNT}; // [RQ4]
    end else if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN)) begin
      rd_word = min_ff;
    end else if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX)) begin
      rd_word = max_ff;
    end else if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_HOME, spl_pkg::SUB_COUNT)) begin
      rd_word = home_ff;
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    nxt_switch = switch_ff;
    nxt_min = min_ff;
    nxt_max = max_ff;
    nxt_modmax = modmax_ff;
    nxt_home = home_ff;
    nxt_ack = od_wr_in || od_rd_in;
    nxt_err = (od_wr_in || od_rd_in) && !mapped;
    nxt_rdata = od_rd_in && mapped ? rd_word : rdata_ff;
    if (od_wr_in) begin
      if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_SWITCH, spl_pkg::SUB_COUNT)) begin
        nxt_switch = od_wdata_in[15:0];
      end
      if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_MODMAX, spl_pkg::SUB_COUNT)) begin
        // a 33rd bit would be needed for the top of the range; writes reach 2^32-1
        nxt_modmax = {1'b0, od_wdata_in};
      end
      if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN)) begin
        nxt_min = od_wdata_in; // [RQ4]
      end
      if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX)) begin
        nxt_max = od_wdata_in; // [RQ4]
      end
      if (hit(od_index_in, od_subindex_in, spl_pkg::IDX_HOME, spl_pkg::SUB_COUNT)) begin
        nxt_home = od_wdata_in;
      end
    end
    nxt_limit_en = limit_en_ff;
    nxt_modulus_en = modulus_en_ff;
    nxt_modmax_act = modmax_act_ff;
    if (restart_in) begin
      nxt_limit_en = switch_ff[spl_pkg::SW_LIMIT_EN_BIT]; // [RQ1]
      nxt_modulus_en = switch_ff[spl_pkg::SW_MODULUS_BIT]; // [RQ11]
      nxt_modmax_act = modmax_ff; // [RQ12]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      switch_ff <= spl_pkg::SWITCH_RST;
      min_ff <= spl_pkg::LIMIT_RST;
      max_ff <= spl_pkg::LIMIT_RST;
      modmax_ff <= spl_pkg::MODMAX_RST;
      home_ff <= spl_pkg::HOME_RST;
      limit_en_ff <= 1'b0;
      modulus_en_ff <= 1'b0;
      modmax_act_ff <= spl_pkg::MODMAX_RST;
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      switch_ff <= nxt_switch;
      min_ff <= nxt_min;
      max_ff <= nxt_max;
      modmax_ff <= nxt_modmax;
      home_ff <= nxt_home;
      limit_en_ff <= nxt_limit_en;
      modulus_en_ff <= nxt_modulus_en;
      modmax_act_ff <= nxt_modmax_act;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
    end
  end

  assign od_rdata_out = rdata_ff;
  assign od_ack_out = ack_ff;
  assign od_err_out = err_ff;

  // ****************************************************************
  // limit checks
  // ****************************************************************
  logic signed [POS_W:0] fb_ff, nxt_fb;
  logic signed [POS_W-1:0] teff_ff, nxt_teff;
  logic stat_ff, nxt_stat;
  logic pwarn_ff, nxt_pwarn;
  logic nwarn_ff, nxt_nwarn;
  logic stop_ff, nxt_stop;
  logic order_ff, nxt_order;
  logic home_err_ff, nxt_home_err;
  logic tgt_over, tgt_under, fb_over, fb_under, home_over, home_under;
  logic pos_mode, mod_active;

  spl_limit_cmp #(.W(POS_W)) u_tgt_cmp (
    .value_in(target_pos_in),
    .min_in(min_ff),
    .max_in(max_ff),
    .over_max_out(tgt_over),
    .under_min_out(tgt_under)
  );

  spl_limit_cmp #(.W(POS_W + 1)) u_fb_cmp (
    .value_in(fb_ff),
    .min_in(min_ff),
    .max_in(max_ff),
    .over_max_out(fb_over),
    .under_min_out(fb_under)
  );

  spl_limit_cmp #(.W(32)) u_home_cmp (
    .value_in(signed'(home_ff)),
    .min_in(min_ff),
    .max_in(max_ff),
    .over_max_out(home_over),
    .under_min_out(home_under)
  );

  assign pos_mode = (op_mode_in == spl_pkg::MODE_PROFILE_POS) ||
                    (op_mode_in == spl_pkg::MODE_CYCLIC_POS);
  assign mod_active = modulus_en_ff && abs_system_in; // [RQ11]

  always_comb begin
    nxt_fb = fb_ff;
    if (pos_step_in) begin
      if (mod_active) begin
        nxt_fb = wrap_pos(fb_ff, pos_delta_in, modmax_act_ff); // [RQ12] [RQ13]
      end else begin
        nxt_fb = fb_ff + (POS_W+1)'(pos_delta_in);
      end
    end
    nxt_teff = target_pos_in;
    nxt_stat = 1'b0;
    nxt_pwarn = 1'b0;
    nxt_nwarn = 1'b0;
    if (limit_en_ff) begin
      if (pos_mode) begin
        nxt_stat = tgt_over || tgt_under; // [RQ6]
        nxt_pwarn = tgt_over; // [RQ6]
        nxt_nwarn = tgt_under; // [RQ6]
        if (tgt_over) begin
          nxt_teff = signed'(max_ff[POS_W-1:0]); // [RQ7]
        end else if (tgt_under) begin
          nxt_teff = signed'(min_ff[POS_W-1:0]); // [RQ7]
        end
      end else begin
        // feedback check in every non-position mode, absolute or incremental [RQ5]
        nxt_pwarn = fb_over; // [RQ8]
        nxt_nwarn = fb_under; // [RQ8]
      end
    end
    nxt_stop = nxt_pwarn || nxt_nwarn; // [RQ7] [RQ8]
    nxt_order = limit_en_ff && (signed'(min_ff) > signed'(max_ff)) &&
                (min_ff != spl_pkg::NO_LIMIT) && (max_ff != spl_pkg::NO_LIMIT); // [RQ9]
    nxt_home_err = limit_en_ff && (home_over || home_under); // [RQ10]
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fb_ff <= '0;
      teff_ff <= '0;
      stat_ff <= 1'b0;
      pwarn_ff <= 1'b0;
      nwarn_ff <= 1'b0;
      stop_ff <= 1'b0;
      order_ff <= 1'b0;
      home_err_ff <= 1'b0;
    end else begin
      fb_ff <= nxt_fb;
      teff_ff <= nxt_teff;
      stat_ff <= nxt_stat;
      pwarn_ff <= nxt_pwarn;
      nwarn_ff <= nxt_nwarn;
      stop_ff <= nxt_stop;
      order_ff <= nxt_order;
      home_err_ff <= nxt_home_err;
    end
  end

  assign pos_feedback_out = fb_ff;
  assign target_eff_out = teff_ff;
  assign status_limit_out = stat_ff;
  assign positive_overtravel_warning_out = pwarn_ff;
  assign negative_overtravel_warning_out = nwarn_ff;
  assign stop_req_out = stop_ff;
  assign limit_order_error_out = order_ff;
  assign home_offset_range_error_out = home_err_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_enable_restart: assert property ( // [RQ1]
    !restart_in && od_wr_in |=> $stable(limit_en_ff))
    else $error("limit enable changed without restart");
  a_min_sentinel: assert property ( // [RQ2]
    limit_en_ff && min_ff == spl_pkg::NO_LIMIT |=> !nwarn_ff)
    else $error("negative warning with minimum sentinel");
  a_max_sentinel: assert property ( // [RQ3]
    limit_en_ff && max_ff == spl_pkg::NO_LIMIT |=> !pwarn_ff)
    else $error("positive warning with maximum sentinel");
  a_count_read: assert property ( // [RQ4]
    od_rd_in && od_index_in == spl_pkg::IDX_LIMIT && od_subindex_in == spl_pkg::SUB_COUNT
    |=> od_ack_out && od_rdata_out == 32'h0000_0002)
    else $error("entry count not two");
  a_target_clamp: assert property ( // [RQ7]
    limit_en_ff && pos_mode && tgt_over |=> stop_ff && teff_ff == signed'($past(max_ff)))
    else $error("target not clamped to maximum");
  a_status_bit: assert property ( // [RQ6]
    limit_en_ff && pos_mode && (tgt_over || tgt_under) |=> stat_ff && (pwarn_ff || nwarn_ff))
    else $error("status bit or warning missing");
  a_fb_warn: assert property ( // [RQ8]
    limit_en_ff && !pos_mode && fb_under |=> nwarn_ff && stop_ff && !stat_ff)
    else $error("feedback negative overtravel missed");
  a_order_err: assert property ( // [RQ9]
    limit_en_ff && signed'(min_ff) > signed'(max_ff) && min_ff != spl_pkg::NO_LIMIT &&
    max_ff != spl_pkg::NO_LIMIT ##1 $stable(min_ff) && $stable(max_ff) |-> order_ff)
    else $error("limit order error missing");
  a_home_err: assert property ( // [RQ10]
    !limit_en_ff |=> !home_err_ff)
    else $error("home error while limit disabled");
  a_mod_wrap: assert property ( // [RQ13]
    mod_active && pos_step_in && pos_delta_in == 1 && fb_ff == signed'({1'b0, modmax_act_ff[31:0]})
    && !modmax_act_ff[32] |=> fb_ff == 0)
    else $error("modulus did not wrap to zero");
  a_mod_range: assert property ( // [RQ12]
    mod_active && pos_step_in && fb_ff >= 0 |=> fb_ff >= 0)
    else $error("modulus count went negative");

  c_clamp_min: cover property (limit_en_ff && pos_mode && tgt_under ##1 nwarn_ff);
  c_fb_over: cover property (limit_en_ff && !pos_mode && fb_over ##1 pwarn_ff);
  c_wrap_neg: cover property (mod_active && pos_step_in && fb_ff == 0 && pos_delta_in < 0);
  c_order: cover property (order_ff);
endmodule

// ### spl_soft_limit_tb.sv
// Purpose: self-checking bench for the soft position limit and modulus block
// Assumes: inputs change at the falling edge, outputs sampled one falling edge later, two for the feedback steps
// Notes: the host model performs all object dictionary accesses
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t: got %h exp %h", $time, (got), (exp)); end end
module spl_soft_limit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in;
  logic reset_n_in;
  logic restart_in;
  logic [15:0] od_index;
  logic [7:0] od_subindex;
  logic od_wr;
  logic od_rd;
  logic [31:0] od_wdata;
  logic [31:0] od_rdata_out;
  logic od_ack_out;
  logic od_err_out;
  logic abs_system_in;
  logic [7:0] op_mode_in;
  logic signed [31:0] target_pos_in;
  logic pos_step_in;
  logic signed [31:0] pos_delta_in;
  logic signed [32:0] pos_feedback_out;
  logic signed [31:0] target_eff_out;
  logic status_limit_out;
  logic pos_warn;
  logic neg_warn;
  logic stop_req_out;
  logic limit_order_error_out;
  logic home_offset_range_error_out;
  int failures;
  int n_tests;
  int cycles;
  logic [31:0] rd;
  logic [1:0] st;

  spl_soft_limit #(.POS_W(32)) u_spl_soft_limit (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .restart_in(restart_in), .od_index_in(od_index), .od_subindex_in(od_subindex),
    .od_wr_in(od_wr), .od_rd_in(od_rd), .od_wdata_in(od_wdata), .od_rdata_out(od_rdata_out),
    .od_ack_out(od_ack_out), .od_err_out(od_err_out), .abs_system_in(abs_system_in),
    .op_mode_in(op_mode_in), .target_pos_in(target_pos_in), .pos_step_in(pos_step_in),
    .pos_delta_in(pos_delta_in), .pos_feedback_out(pos_feedback_out),
    .target_eff_out(target_eff_out), .status_limit_out(status_limit_out),
    .positive_overtravel_warning_out(pos_warn), .negative_overtravel_warning_out(neg_warn),
    .stop_req_out(stop_req_out), .limit_order_error_out(limit_order_error_out),
    .home_offset_range_error_out(home_offset_range_error_out));

  spl_host_model u_spl_host_model (.clk_in(clk_in), .od_index_out(od_index),
    .od_subindex_out(od_subindex), .od_wr_out(od_wr), .od_rd_out(od_rd),
    .od_wdata_out(od_wdata), .od_rdata_in(od_rdata_out), .od_ack_in(od_ack_out),
    .od_err_in(od_err_out));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    u_spl_host_model.access(1'b1, i, s, d, rd, st);
    `CHK(st, 2'b10)
  endtask

  task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    u_spl_host_model.access(1'b0, i, s, 32'h0000_0000, rd, st);
    `CHK(st, 2'b10)
    `CHK(rd, e)
  endtask

  // flags are {status, positive warning, negative warning, stop}
  task automatic tgt(input logic [31:0] t, input logic [31:0] e, input logic [3:0] f);
    @(negedge clk_in);
    target_pos_in = t;
    @(negedge clk_in);
    `CHK(target_eff_out, e)
    `CHK({status_limit_out, pos_warn, neg_warn, stop_req_out}, f)
  endtask

  // feedback warnings trail the step by two cycles
  task automatic stp(input logic [31:0] d, input logic [32:0] e, input logic [2:0] f);
    @(negedge clk_in);
    pos_step_in = 1'b1;
    pos_delta_in = d;
    @(negedge clk_in);
    pos_step_in = 1'b0;
    @(negedge clk_in);
    `CHK(pos_feedback_out, e)
    `CHK({pos_warn, neg_warn, stop_req_out}, f)
  endtask

  task automatic restart();
    @(negedge clk_in);
    restart_in = 1'b1;
    @(negedge clk_in);
    restart_in = 1'b0;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    failures = 0;
    n_tests = 0;
    cycles = 0;
    reset_n_in = 1'b0;
    restart_in = 1'b0;
    abs_system_in = 1'b0;
    op_mode_in = spl_pkg::MODE_PROFILE_POS;
    target_pos_in = 32'h0000_0000;
    pos_step_in = 1'b0;
    pos_delta_in = 32'h0000_0000;
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'b1;
    rdc(spl_pkg::IDX_SWITCH, 8'h00, 32'h0000_0000);
    rdc(spl_pkg::IDX_LIMIT, spl_pkg::SUB_COUNT, 32'h0000_0002);
    rdc(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'h8000_0000);
    rdc(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX, 32'h8000_0000);
    rdc(spl_pkg::IDX_MODMAX, 8'h00, 32'h0000_0000);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_COUNT, 32'h0000_0005);
    rdc(spl_pkg::IDX_LIMIT, spl_pkg::SUB_COUNT, 32'h0000_0002);
    u_spl_host_model.access(1'b0, 16'h1234, 8'h00, 32'h0000_0000, rd, st);
    `CHK(st, 2'b11)
    $display("test registers finished");
    // host keeps minimum below maximum here
    wr(spl_pkg::IDX_SWITCH, 8'h00, 32'h0000_0001);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'hFFFF_FF9C);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX, 32'h0000_0064);
    rdc(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'hFFFF_FF9C);
    tgt(32'h0000_00C8, 32'h0000_00C8, 4'b0000);
    restart();
    for (int m = 0; m < 2; m++) begin
      op_mode_in = (m == 0) ? spl_pkg::MODE_PROFILE_POS : spl_pkg::MODE_CYCLIC_POS;
      tgt(32'h0000_00C8, 32'h0000_0064, 4'b1101);
      tgt(32'hFFFF_FF38, 32'hFFFF_FF9C, 4'b1011);
      tgt(32'h0000_0032, 32'h0000_0032, 4'b0000);
    end
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX, 32'h8000_0000);
    tgt(32'h7FFF_FFFF, 32'h7FFF_FFFF, 4'b0000);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MAX, 32'h0000_0064);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'h8000_0000);
    tgt(32'h8000_0001, 32'h8000_0001, 4'b0000);
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'hFFFF_FF9C);
    $display("test target clamp finished");
    op_mode_in = 8'h03;
    stp(32'h0000_0096, 33'h0_0000_0096, 3'b101);
    stp(32'hFFFF_FED4, 33'h1_FFFF_FF6A, 3'b011);
    stp(32'h0000_0096, 33'h0_0000_0000, 3'b000);
    abs_system_in = 1'b1;
    stp(32'h0000_0065, 33'h0_0000_0065, 3'b101);
    stp(32'hFFFF_FF9B, 33'h0_0000_0000, 3'b000);
    $display("test feedback finished");
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'h0000_00C8);
    @(negedge clk_in);
    `CHK(limit_order_error_out, 1'b1)
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'h0000_000A);
    @(negedge clk_in);
    `CHK({limit_order_error_out, home_offset_range_error_out}, 2'b01)
    wr(spl_pkg::IDX_HOME, 8'h00, 32'h0000_0032);
    @(negedge clk_in);
    `CHK(home_offset_range_error_out, 1'b0)
    wr(spl_pkg::IDX_LIMIT, spl_pkg::SUB_MIN, 32'hFFFF_FF9C);
    $display("test setting errors finished");
    wr(spl_pkg::IDX_MODMAX, 8'h00, 32'h0000_0009);
    wr(spl_pkg::IDX_SWITCH, 8'h00, 32'h0000_0003);
    restart();
    stp(32'h0000_0009, 33'h0_0000_0009, 3'b000);
    stp(32'h0000_0001, 33'h0_0000_0000, 3'b000);
    stp(32'hFFFF_FFFF, 33'h0_0000_0009, 3'b000);
    stp(32'h0000_0003, 33'h0_0000_0002, 3'b000);
    abs_system_in = 1'b0;
    stp(32'hFFFF_FFFB, 33'h1_FFFF_FFFD, 3'b000);
    $display("test modulus finished");
    complete_run();
  end
endmodule
